// ==== sbc_spi_defs.svh ====
// Constants for the serial register access block.
`ifndef SBC_SPI_DEFS_SVH
`define SBC_SPI_DEFS_SVH

`define FRAME_BITS 16
`define ADDR_BITS 7
`define BYTE_BITS 8
`define CNT_BITS 5
`define IDX_BITS 5
`define NUM_CTRL 15
`define NUM_STAT 9
`define NUM_REGS 24
`define ADDR_IDENT 7'h7E
`define MSC_IDX 5'h00
`define MODE_HI 7
`define MODE_LO 6
`define MODE_SOFT_RESET 2'h3
`define ID_NIBBLE_BITS 4

// Order: 15 control registers, then 9 status registers.
`define ADDR_TABLE '{7'h01, 7'h02, 7'h03, 7'h04, 7'h06, 7'h07, 7'h08, 7'h0C, 7'h0D, \
  7'h0E, 7'h14, 7'h17, 7'h18, 7'h19, 7'h1C, 7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h46, \
  7'h47, 7'h54, 7'h55}
`define RESV_TABLE '{8'h00, 8'h04, 8'h08, 8'h1C, 8'h3F, 8'h58, 8'hC0, 8'h88, 8'h88, \
  8'h8F, 8'h88, 8'h00, 8'h00, 8'h00, 8'h00, 8'hB0, 8'h00, 8'hF8, 8'h10, 8'hF9, 8'h08, \
  8'hEF, 8'h70, 8'hF0}
`define HWMOD_TABLE '{8'hFC, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, \
  8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, \
  8'h00, 8'h00, 8'h00}
`define POR_TABLE '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, \
  8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, \
  8'h00, 8'h00, 8'h00}
`define RESTART_TABLE '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, \
  8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, \
  8'h00, 8'h00, 8'h00}
`define KEEP_TABLE '{8'h23, 8'hD9, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, \
  8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, \
  8'hFF, 8'hFF, 8'hFF}

`endif

// ==== sbc_spi_pkg.sv ====
// Types shared by the serial register access block and its bench.
package sbc_spi_pkg;
  `include "sbc_spi_defs.svh"

  typedef struct packed {
    logic [`BYTE_BITS-1:0] data;
    logic wr;
    logic [`ADDR_BITS-1:0] addr;
  } frame_t;

  typedef struct packed {
    logic valid;
    logic [`IDX_BITS-1:0] idx;
    logic [`BYTE_BITS-1:0] bits;
  } hw_upd_t;

  typedef logic [`NUM_CTRL-1:0][`BYTE_BITS-1:0] ctrl_bank_t;
  typedef logic [`NUM_STAT-1:0][`BYTE_BITS-1:0] stat_evt_t;
endpackage : sbc_spi_pkg

// ==== sbc_spi_register_access.sv ====
// Serial frame decoder and register bank of the system basis chip.
`timescale 1ns/10ps
module sbc_spi_register_access #(
  parameter int FRAME_BITS = `FRAME_BITS,
  // Identity nibbles are arbitrary values.
  parameter logic [3:0] FAMILY_ID = 4'h5,
  parameter logic [3:0] PRODUCT_ID = 4'hA
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic spiClk,
  input wire logic spiCsN,
  input wire logic spiMosi,
  output logic spiMisoOut,
  output logic spiMisoOeN,
  input wire sbc_spi_pkg::hw_upd_t hwUpd,
  input wire sbc_spi_pkg::stat_evt_t statEvt,
  input wire logic restartReq,
  output sbc_spi_pkg::ctrl_bank_t ctrlRegs,
  output logic softResetPulse
);
  import sbc_spi_pkg::*;

  if (FRAME_BITS != `FRAME_BITS) begin : g_check
    $error("Only sixteen-bit frames are served.");
  end

  localparam logic [`ADDR_BITS-1:0] ADDRS [`NUM_REGS] = `ADDR_TABLE;
  localparam logic [7:0] RESV [`NUM_REGS] = `RESV_TABLE;
  localparam logic [7:0] HWMOD [`NUM_REGS] = `HWMOD_TABLE;
  localparam logic [7:0] POR [`NUM_REGS] = `POR_TABLE;
  localparam logic [7:0] RESTART [`NUM_REGS] = `RESTART_TABLE;
  localparam logic [7:0] KEEP [`NUM_REGS] = `KEEP_TABLE;
  localparam logic [`CNT_BITS-1:0] LAST_BIT = `CNT_BITS'(`FRAME_BITS - 1);
  localparam logic [`CNT_BITS-1:0] FULL_CNT = `CNT_BITS'(`FRAME_BITS);

  // Link-clock domain.
  logic csOff;
  logic [`CNT_BITS-1:0] rxCnt_r;
  logic [`FRAME_BITS-1:0] rxShift_r;
  logic [`FRAME_BITS-1:0] frameHold_r;
  logic frameTgl_r;
  logic [`CNT_BITS-1:0] txCnt_r;
  logic misoBit_r;
  logic misoOeN_r;

  // System-clock domain.
  logic [2:0] frameSync_r;
  logic frameEvt;
  frame_t frame;
  logic hit;
  logic [`IDX_BITS-1:0] hitIdx;
  logic [7:0] regs_r [`NUM_REGS];
  logic [7:0] regs_nxt [`NUM_REGS];
  logic [7:0] rdByte_r;
  logic [7:0] addrEcho_r;
  logic softRst_r;
  logic [`FRAME_BITS-1:0] txWord;

  // Deselect clears the frame counters, so a short frame is dropped whole.
  assign csOff = rst | spiCsN;

  always_ff @(negedge spiClk or posedge csOff) begin
    if (csOff) begin
      rxCnt_r <= '0;
      rxShift_r <= '0;
    end else begin
      rxShift_r <= {spiMosi, rxShift_r[`FRAME_BITS-1:1]};
      if (rxCnt_r != FULL_CNT) begin
        rxCnt_r <= rxCnt_r + `CNT_BITS'(1);
      end
    end
  end

  always_ff @(negedge spiClk or posedge rst) begin
    if (rst) begin
      frameHold_r <= '0;
      frameTgl_r <= 1'b0;
    end else if (!spiCsN && rxCnt_r == LAST_BIT) begin
      frameHold_r <= {spiMosi, rxShift_r[`FRAME_BITS-1:1]};
      frameTgl_r <= ~frameTgl_r;
    end
  end

  // The answer word is quasi-static: it settles a few system clocks after a frame.
  assign txWord = {rdByte_r, addrEcho_r};

  always_ff @(posedge spiClk or posedge csOff) begin
    if (csOff) begin
      txCnt_r <= '0;
      misoBit_r <= 1'b0;
    end else begin
      if (txCnt_r != FULL_CNT) begin
        txCnt_r <= txCnt_r + `CNT_BITS'(1);
        misoBit_r <= txWord[txCnt_r[3:0]];
      end else begin
        misoBit_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge spiClk or posedge csOff) begin
    if (csOff) begin
      misoOeN_r <= 1'b1;
    end else begin
      misoOeN_r <= 1'b0;
    end
  end

  assign spiMisoOut = misoBit_r;
  assign spiMisoOeN = misoOeN_r;

  // Toggle crossing; the held word is stable long before the toggle lands.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      frameSync_r <= '0;
    end else begin
      frameSync_r <= {frameSync_r[1:0], frameTgl_r};
    end
  end

  assign frameEvt = frameSync_r[1] ^ frameSync_r[2];

  assign frame = frame_t'(frameHold_r);

  always_comb begin
    hit = 1'b0;
    hitIdx = '0;
    for (int i = 0; i < `NUM_REGS; i++) begin
      if (frame.addr == ADDRS[i]) begin
        hit = 1'b1;
        hitIdx = `IDX_BITS'(i);
      end
    end
  end

  always_comb begin
    for (int i = 0; i < `NUM_REGS; i++) begin
      regs_nxt[i] = regs_r[i];
      if (softRst_r) begin
        regs_nxt[i] = POR[i];
      end else if (restartReq) begin
        regs_nxt[i] = (regs_r[i] & KEEP[i]) | (RESTART[i] & ~KEEP[i]);
      end else begin
        if (frameEvt && hit && hitIdx == `IDX_BITS'(i)) begin
          if (i < `NUM_CTRL && frame.wr) begin
            regs_nxt[i] = (regs_r[i] & RESV[i]) | (frame.data & ~RESV[i]);
          end else if (i >= `NUM_CTRL && !frame.wr) begin
            regs_nxt[i] = '0;
          end
        end
        if (i < `NUM_CTRL && hwUpd.valid && hwUpd.idx == `IDX_BITS'(i)) begin
          regs_nxt[i] = (regs_nxt[i] & ~HWMOD[i]) | (hwUpd.bits & HWMOD[i]);
        end
        // An event in the clearing cycle survives the clear.
        if (i >= `NUM_CTRL) begin
          regs_nxt[i] = regs_nxt[i] | statEvt[i - `NUM_CTRL];
        end
      end
      regs_nxt[i] = regs_nxt[i] & ~RESV[i];
    end
  end

  // Bits change only on the above causes.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `NUM_REGS; i++) begin
        regs_r[i] <= POR[i];
      end
    end else begin
      for (int i = 0; i < `NUM_REGS; i++) begin
        regs_r[i] <= regs_nxt[i];
      end
    end
  end

  // Read reports value before any change.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdByte_r <= '0;
      addrEcho_r <= '0;
    end else if (frameEvt) begin
      addrEcho_r <= {frame.wr, frame.addr};
      if (hit) begin
        rdByte_r <= regs_r[hitIdx] & ~RESV[hitIdx];
      end else if (frame.addr == `ADDR_IDENT) begin
        rdByte_r <= {FAMILY_ID, PRODUCT_ID};
      end else begin
        rdByte_r <= '0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      softRst_r <= 1'b0;
    end else begin
      softRst_r <= frameEvt && hit && hitIdx == `MSC_IDX && frame.wr &&
        frame.data[`MODE_HI:`MODE_LO] == `MODE_SOFT_RESET;
    end
  end

  assign softResetPulse = softRst_r;

  always_comb begin
    for (int i = 0; i < `NUM_CTRL; i++) begin
      ctrlRegs[i] = regs_r[i];
    end
  end
endmodule : sbc_spi_register_access

// ==== sbc_spi_checker_properties.sv ====
// Port checks for the serial register access block.
`timescale 1ns/10ps
module sbc_spi_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic spiCsN,
  input wire logic spiMisoOeN,
  input wire sbc_spi_pkg::hw_upd_t hwUpd,
  input wire logic restartReq,
  input wire sbc_spi_pkg::ctrl_bank_t ctrlRegs,
  input wire logic softResetPulse
);
  import sbc_spi_pkg::*;
  logic [3:0] idleCnt_r;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // A frame lands a few cycles after deselect, so the restart, hold and hardware checks judge only long quiet spans.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idleCnt_r <= 4'h0;
    end else if (!spiCsN) begin
      idleCnt_r <= 4'h0;
    end else if (idleCnt_r != 4'hF) begin
      idleCnt_r <= idleCnt_r + 4'h1;
    end
  end
  property p_oe_idle;
    spiCsN |-> spiMisoOeN;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("MISO on while idle");
  property p_rst_clear;
    disable iff (1'b0) rst |-> ctrlRegs == '0 && !softResetPulse;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("reset value");
  property p_soft_one;
    softResetPulse |=> !softResetPulse;
  endproperty
  a_soft_one: assert property (p_soft_one) else $error("soft pulse long");
  property p_soft_load;
    softResetPulse |=> ctrlRegs == '0;
  endproperty
  a_soft_load: assert property (p_soft_load) else $error("soft reset load");
  property p_restart;
    restartReq && !hwUpd.valid && idleCnt_r > 4'h8 |=> ctrlRegs[0] == ($past(ctrlRegs[0]) & 8'h23)
      && ctrlRegs[1] == ($past(ctrlRegs[1]) & 8'hD9);
  endproperty
  a_restart: assert property (p_restart) else $error("restart load");
  property p_resv;
    (ctrlRegs[1] & 8'h04) == 8'h00 && (ctrlRegs[4] & 8'h3F) == 8'h00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");
  property p_hold;
    idleCnt_r > 4'h8 && !hwUpd.valid && !restartReq |=> $stable(ctrlRegs);
  endproperty
  a_hold: assert property (p_hold) else $error("control changed");
  property p_hw;
    hwUpd.valid && hwUpd.idx == 5'h00 && !restartReq && idleCnt_r > 4'h8
      |=> (ctrlRegs[0] & 8'hFC) == ($past(hwUpd.bits) & 8'hFC);
  endproperty
  a_hw: assert property (p_hw) else $error("hardware update");
endmodule : sbc_spi_checker

bind sbc_spi_register_access sbc_spi_checker i_chk (.clk_sys(clk_sys), .rst(rst),
  .spiCsN(spiCsN), .spiMisoOeN(spiMisoOeN), .hwUpd(hwUpd), .restartReq(restartReq),
  .ctrlRegs(ctrlRegs), .softResetPulse(softResetPulse));

// ==== spi_master_model.sv ====
// Behavioural serial master that frames register accesses.
`timescale 1ns/10ps
module spi_master_model (
  output logic spiClk,
  output logic spiCsN,
  output logic spiMosi,
  input wire logic spiMisoOut
);
  initial begin
    spiClk = 1'b0;
    spiCsN = 1'b1;
    spiMosi = 1'b0;
  end
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = '0;
    spiCsN = 1'b0;
    #20;
    for (int i = 0; i < n; i++) begin
      spiMosi = tx[i];
      spiClk = 1'b1;
      #7.5;
      rx[i] = spiMisoOut;
      spiClk = 1'b0;
      #7.5;
    end
    #20;
    spiCsN = 1'b1;
    // A released line shows the inverse so stale data never passes as valid.
    spiMosi = ~spiMosi;
    #320;
  endtask : xfer
endmodule : spi_master_model

// ==== testbench.sv ====
// Self-checking bench for the serial register access block.
`timescale 1ns/10ps
module testbench;
  import sbc_spi_pkg::*;
  localparam logic [3:0] FAM = 4'h3; // Arbitrary identity value.
  localparam logic [3:0] PROD = 4'hC; // Arbitrary identity value.
  logic clk_sys = 1'b0;
  logic rst = 1'b0;
  logic restartReq = 1'b0;
  logic spiClk, spiCsN, spiMosi, spiMisoOut, spiMisoOeN, softResetPulse;
  hw_upd_t hwUpd = '0;
  stat_evt_t statEvt = '0;
  ctrl_bank_t ctrlRegs;
  logic [15:0] rx;
  int nErrors = 0;
  int cmpCount = 0;
  // Reserved bits written zero, one probe excepted.
  logic [23:0] rows [11] = '{24'h001581, 24'h150001, 24'h00FF82, 24'hFB0002,
    {FAM, PROD, 16'h00FE}, {FAM, PROD, 16'h007E}, 24'h00FF85, 24'h000005,
    24'h4F0040, 24'h000040, 24'h000001};
  always #20 clk_sys = ~clk_sys;
  spi_master_model i_mst (.spiClk(spiClk), .spiCsN(spiCsN), .spiMosi(spiMosi),
    .spiMisoOut(spiMisoOut));
  sbc_spi_register_access #(.FAMILY_ID(FAM), .PRODUCT_ID(PROD)) i_dut (.clk_sys(clk_sys),
    .rst(rst), .spiClk(spiClk), .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMisoOut(spiMisoOut),
    .spiMisoOeN(spiMisoOeN), .hwUpd(hwUpd), .statEvt(statEvt), .restartReq(restartReq),
    .ctrlRegs(ctrlRegs), .softResetPulse(softResetPulse));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    if (nErrors == 0 && cmpCount > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #100000;
    nErrors++;
    end_of_test();
  end
  initial begin
    #1 rst = 1'b1;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    statEvt[0] = 8'hFF;
    @(negedge clk_sys);
    statEvt = '0;
    for (int k = 0; k < 11; k++) begin
      i_mst.xfer(rows[k][15:0], 16, rx);
      if (k > 0) chk(rx, {rows[k-1][23:16], rows[k-1][7:0]});
    end
    repeat (4) @(negedge clk_sys);
    hwUpd = '{1'b1, 5'h00, 8'hFF};
    @(negedge clk_sys);
    hwUpd = '0;
    chk({8'h00, ctrlRegs[0]}, 16'h00FD);
    restartReq = 1'b1;
    @(negedge clk_sys);
    restartReq = 1'b0;
    chk({ctrlRegs[1], ctrlRegs[0]}, 16'hD921);
    i_mst.xfer(16'h0381, 10, rx);
    chk({8'h00, ctrlRegs[0]}, 16'h0021);
    i_mst.xfer(16'hC081, 16, rx);
    chk({ctrlRegs[1], ctrlRegs[0]}, 16'h0000);
    i_mst.xfer(16'h1581, 16, rx);
    chk({8'h00, ctrlRegs[0]}, 16'h0015);
    @(negedge clk_sys);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk({8'h00, ctrlRegs[0]}, 16'h0000);
    rst = 1'b0;
    end_of_test();
  end
endmodule : testbench
